// file: rtl/ocs_clock_select.sv
/*
 * Oscillator selection and system clock enable generation.
 * Assumes raw oscillator levels arrive asynchronously on pins and
 * are at most a quarter of MCLK; faster crystals alias when sampled.
 * Every derived clock leaves this block as a one-cycle enable.
 */
// The address map and the plain strobed port were decided locally.
`timescale 1ns/100ps
`include "ocs_map.svh"

// Contract
// - four sources: two fast, two slow
// - select bit and divider choose, dynamically
// - oscillator per role fixed by straps
// - fast rc runs at 4, 8, 12 MHz
// - strap marks crystal at/above 1 MHz
// - fast rc frees port d pins
// - unused slow crystal frees its pins
// - slow crystal 32.768 kHz, rc 32 kHz
// - low power bit: 0 quick, 1 low power
// - low power bit clears at power-on
// - slow crystal clock valid in both modes
// - slow crystal unusable until start-up done
// - slow clock feeds watchdog and time base
// - halt stops system clock, slow continues
// - divider codes: slow, then fast/64 to /2
// - slow clock from crystal or rc strap
// - crystal ready after 1024 fast ticks
// - slow rc ready within two ticks
module ocs_clock_select #(
    parameter int SLOW_QS_WAIT = 1024,   // slow ticks, quick start
    parameter int SLOW_LP_WAIT = 4096    // slow ticks, low power
) (
    input  wire logic             MCLK,
    input  wire logic             RESET,
    input  wire logic [7:0]       ADDR,
    input  wire logic [7:0]       WDATA,
    input  wire logic             WR,
    input  wire logic             RD,
    output logic [7:0]            RDATA,
    input  wire logic             OSC_FAST_XTAL,
    input  wire logic             OSC_FAST_RC,
    input  wire logic             OSC_SLOW_XTAL,
    input  wire logic             OSC_SLOW_RC,
    input  wire ocs_pkg::ocs_cfg_s CFG,
    input  wire logic             SYS_HALT,
    input  wire logic             SLOW_STOP,
    output logic                  SYS_CLK_EN,
    output logic                  SLOW_CLK_EN,
    output logic                  FAST_XTAL_ON,
    output logic                  FAST_XTAL_HI_FREQ,
    output logic                  FAST_RC_ON,
    output logic [1:0]            FAST_RC_FREQ,
    output logic                  SLOW_XTAL_ON,
    output logic                  SLOW_XTAL_LOWPOWER,
    output logic                  SLOW_RC_ON,
    output logic                  PORT_D_GPIO_EN,
    output logic                  SLOW_PINS_GPIO_EN
);
    import ocs_pkg::*;

    // ************************************************************
    // synchronisers and tick detection
    // ************************************************************
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [1:0] prev_reg;
    logic [1:0] prev_next;
    logic       fast_tick;
    logic       slow_tick;
    logic       fast_on;    // fast source running, decoded with the selection
    ocs_cfg_s   cfg_reg,   cfg_next;

    // first stage feeds only the second
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            prev_reg  <= 2'h0;
        end else begin
            sync1_reg <= {OSC_SLOW_RC, OSC_SLOW_XTAL, OSC_FAST_RC, OSC_FAST_XTAL};
            sync2_reg <= sync1_reg;
            prev_reg  <= prev_next;
        end
    end

    // source per role taken from the straps, then rising-edge detect
    always_comb begin
        prev_next[0] = cfg_reg.fast_rc ? sync2_reg[1] : sync2_reg[0];
        prev_next[1] = cfg_reg.slow_rc ? sync2_reg[3] : sync2_reg[2];
        fast_tick    = prev_next[0] & ~prev_reg[0] & fast_on;
        slow_tick    = prev_next[1] & ~prev_reg[1] & ~SLOW_STOP;
    end

    // ************************************************************
    // straps and registers
    // ************************************************************
    logic      cfg_done_reg, cfg_done_next;
    ocs_mode_s mode_reg,  mode_next;
    logic      lp_reg,    lp_next;
    logic [7:0] rdata_next;
    logic      fast_rdy_reg, slow_rdy;

    // straps are caught on the first edge after reset release
    always_comb begin
        cfg_next      = cfg_done_reg ? cfg_reg : CFG;
        cfg_done_next = 1'b1;
        mode_next     = mode_reg;
        lp_next       = lp_reg;
        rdata_next    = 8'h00;
        if (WR) begin
            if (ADDR == `OCS_ADDR_MODE) begin
                mode_next = {WDATA[7:4], WDATA[1:0]};
            end else if (ADDR == `OCS_ADDR_TBC) begin
                lp_next = WDATA[`OCS_TBC_LP_BIT];
            end
        end
        if (RD) begin
            if (ADDR == `OCS_ADDR_MODE) begin
                rdata_next = {mode_reg.sysclk_divider_sel, mode_reg.fast_wake_en,
                              slow_rdy, fast_rdy_reg, mode_reg.idle_en,
                              mode_reg.fast_slow_select};
            end else if (ADDR == `OCS_ADDR_TBC) begin
                rdata_next[`OCS_TBC_LP_BIT] = lp_reg;
            end else if (ADDR == `OCS_ADDR_CFG) begin
                rdata_next = {3'h0, cfg_reg};
            end
        end
    end

    // low power bit resets to quick start
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            cfg_reg      <= '0;
            cfg_done_reg <= 1'b0;
            mode_reg     <= ocs_mode_s'(`OCS_MODE_RESET);
            lp_reg       <= 1'b0;
            RDATA        <= 8'h00;
        end else begin
            cfg_reg      <= cfg_next;
            cfg_done_reg <= cfg_done_next;
            mode_reg     <= mode_next;
            lp_reg       <= lp_next;
            RDATA        <= rdata_next;
        end
    end

    // ************************************************************
    // fast divider and system clock selection
    // ************************************************************
    logic [5:0] div_reg, div_next;
    logic [3:0] sel_reg, sel_next;    // applied {select, divider}
    logic       sel_slow;
    logic       sys_pulse;
    logic [5:0] mask;

    // decode the applied selection
    always_comb begin
        sel_slow = ~sel_reg[3] & (sel_reg[2:0] <= `OCS_DIV_SLOW_MAX);
        fast_on  = cfg_done_reg & ~SYS_HALT & ~sel_slow;
        case (sel_reg[2:0])
            3'h2:    mask = 6'h3F;  // fast/64
            3'h3:    mask = 6'h1F;
            3'h4:    mask = 6'h0F;
            3'h5:    mask = 6'h07;
            3'h6:    mask = 6'h03;
            default: mask = 6'h01;  // fast/2
        endcase
        if (sel_reg[3]) begin
            mask = 6'h00;           // undivided fast clock
        end
    end

    // one counter serves every ratio so divided edges stay aligned
    always_comb begin
        div_next = fast_tick ? div_reg + 6'h01 : div_reg;
        if (sel_slow) begin
            sys_pulse = slow_tick & slow_rdy;
        end else begin
            sys_pulse = fast_tick & fast_rdy_reg & ((div_reg & mask) == mask);
        end
        sys_pulse = sys_pulse & ~SYS_HALT;
        // a new choice waits for a boundary of the old clock
        sel_next = sel_reg;
        if (sys_pulse | SYS_HALT | (sel_slow ? ~slow_rdy : ~fast_rdy_reg)) begin
            sel_next = {mode_reg.fast_slow_select, mode_reg.sysclk_divider_sel};
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            div_reg <= 6'h00;
            sel_reg <= 4'h8;
        end else begin
            div_reg <= div_next;
            sel_reg <= sel_next;
        end
    end

    // ************************************************************
    // oscillator ready tracking
    // ************************************************************
    logic [10:0] fcnt_reg, fcnt_next;
    logic        fast_rdy_next;
    ocs_slow_e   sst_reg, sst_next;
    logic [15:0] scnt_reg, scnt_next;
    logic [15:0] slow_wait;

    // fast ready clears while the fast source is stopped
    always_comb begin
        fcnt_next     = fcnt_reg;
        fast_rdy_next = fast_rdy_reg;
        if (!fast_on) begin
            fcnt_next     = 11'h000;
            fast_rdy_next = 1'b0;
        end else if (fast_tick && !fast_rdy_reg) begin
            if (cfg_reg.fast_rc) begin
                fast_rdy_next = 1'b1;
            end else begin
                fcnt_next = fcnt_reg + 11'h001;
                if (fcnt_next == `OCS_FAST_XTAL_WAIT) begin
                    fast_rdy_next = 1'b1;
                end
            end
        end
    end

    // low power mode only lengthens the crystal start-up
    always_comb begin
        slow_wait = lp_reg ? 16'(SLOW_LP_WAIT) : 16'(SLOW_QS_WAIT);
        if (cfg_reg.slow_rc) begin
            slow_wait = 16'(`OCS_SLOW_RC_WAIT);
        end
        sst_next  = sst_reg;
        scnt_next = scnt_reg;
        slow_rdy  = (sst_reg == SLOW_READY);
        case (sst_reg)
            SLOW_OFF: begin
                scnt_next = 16'h0000;
                if (cfg_done_reg && !SLOW_STOP) begin
                    sst_next = SLOW_START;
                end
            end
            SLOW_START: begin
                if (SLOW_STOP) begin
                    sst_next = SLOW_OFF;
                end else if (slow_tick) begin
                    scnt_next = scnt_reg + 16'h0001;
                    if (scnt_next >= slow_wait) begin
                        sst_next = SLOW_READY;
                    end
                end
            end
            default: begin
                if (SLOW_STOP) begin
                    sst_next = SLOW_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            fcnt_reg     <= 11'h000;
            fast_rdy_reg <= 1'b0;
            sst_reg      <= SLOW_OFF;
            scnt_reg     <= 16'h0000;
        end else begin
            fcnt_reg     <= fcnt_next;
            fast_rdy_reg <= fast_rdy_next;
            sst_reg      <= sst_next;
            scnt_reg     <= scnt_next;
        end
    end

    // ************************************************************
    // registered outputs
    // ************************************************************
    // slow clock keeps running through halt for watchdog and time base
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            SYS_CLK_EN         <= 1'b0;
            SLOW_CLK_EN        <= 1'b0;
            FAST_XTAL_ON       <= 1'b0;
            FAST_XTAL_HI_FREQ  <= 1'b0;
            FAST_RC_ON         <= 1'b0;
            FAST_RC_FREQ       <= 2'h0;
            SLOW_XTAL_ON       <= 1'b0;
            SLOW_XTAL_LOWPOWER <= 1'b0;
            SLOW_RC_ON         <= 1'b0;
            PORT_D_GPIO_EN     <= 1'b0;
            SLOW_PINS_GPIO_EN  <= 1'b0;
        end else begin
            SYS_CLK_EN         <= sys_pulse;
            SLOW_CLK_EN        <= slow_tick & slow_rdy;
            FAST_XTAL_ON       <= fast_on & ~cfg_reg.fast_rc;
            FAST_XTAL_HI_FREQ  <= cfg_reg.xtal_hi;
            FAST_RC_ON         <= fast_on & cfg_reg.fast_rc;
            FAST_RC_FREQ       <= cfg_reg.rc_freq;
            SLOW_XTAL_ON       <= cfg_done_reg & ~cfg_reg.slow_rc & ~SLOW_STOP;
            SLOW_XTAL_LOWPOWER <= lp_reg;
            SLOW_RC_ON         <= cfg_done_reg & cfg_reg.slow_rc & ~SLOW_STOP;
            PORT_D_GPIO_EN     <= cfg_done_reg & cfg_reg.fast_rc;
            SLOW_PINS_GPIO_EN  <= cfg_done_reg & cfg_reg.slow_rc;
        end
    end

endmodule : ocs_clock_select

// file: pkg/ocs_map.svh
/*
 * Register offsets, field positions, reset values and counts of the
 * oscillator and clock select block.
 * Assumes an 8-bit register port and a 20 MHz MCLK.
 */
`ifndef OCS_MAP_SVH
`define OCS_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OCS_ADDR_MODE      8'h00
`define OCS_ADDR_TBC       8'h01
`define OCS_ADDR_CFG       8'h02

// ****************************************************************
// fields and reset values
// ****************************************************************
`define OCS_MODE_RESET     6'h03
`define OCS_MODE_SLOW_RDY  3
`define OCS_MODE_FAST_RDY  2
`define OCS_TBC_LP_BIT     0
`define OCS_DIV_SLOW_MAX   3'h1

// ****************************************************************
// timing counts, in oscillator ticks, and the MCLK rate in Hz
// ****************************************************************
`define OCS_FAST_XTAL_WAIT 11'h400
`define OCS_SLOW_RC_WAIT   2
`define OCS_MCLK_HZ        20000000

`endif

// file: pkg/ocs_pkg.sv
/*
 * Types of the oscillator and clock select block.
 * Assumes ocs_map.svh carries the numeric constants.
 */
package ocs_pkg;

    // configuration straps, caught once after reset
    typedef struct packed {
        logic       fast_rc;     // 1: internal fast rc, 0: crystal
        logic       slow_rc;     // 1: internal slow rc, 0: crystal
        logic [1:0] rc_freq;     // 0: 4 MHz, 1: 8 MHz, 2: 12 MHz
        logic       xtal_hi;     // crystal at or above 1 MHz
    } ocs_cfg_s;

    // system mode register fields held by the block
    typedef struct packed {
        logic [2:0] sysclk_divider_sel;
        logic       fast_wake_en;
        logic       idle_en;
        logic       fast_slow_select;
    } ocs_mode_s;

    // start-up of the slow oscillator
    typedef enum logic [1:0] {
        SLOW_OFF,
        SLOW_START,
        SLOW_READY
    } ocs_slow_e;

endpackage : ocs_pkg

// file: bench/ocs_clock_select_sva.sv
/*
 * Port checker of the oscillator and clock select block.
 * Assumes it is bound into ocs_clock_select on one MCLK domain.
 */
`timescale 1ns/100ps
module ocs_clock_select_sva (
    input wire logic       MCLK,
    input wire logic       RESET,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       SYS_HALT,
    input wire logic       SLOW_STOP,
    input wire logic       SYS_CLK_EN,
    input wire logic       SLOW_CLK_EN,
    input wire logic       FAST_XTAL_ON,
    input wire logic       FAST_RC_ON,
    input wire logic       SLOW_XTAL_ON,
    input wire logic       SLOW_RC_ON,
    input wire logic       SLOW_XTAL_LOWPOWER,
    input wire logic       PORT_D_GPIO_EN,
    input wire logic       SLOW_PINS_GPIO_EN
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    // a timebase write, then the register stage before the output copy
    sequence s_lp_wr;
        WR && ADDR == 8'h01 ##1 1'b1;
    endsequence
    property p_lp; s_lp_wr |=> SLOW_XTAL_LOWPOWER == $past(WDATA[0], 2); endproperty
    property p_por; $fell(RESET) |-> !SLOW_XTAL_LOWPOWER && !SYS_CLK_EN; endproperty
    property p_rdat; RDATA != 8'h00 |-> $past(RD); endproperty
    property p_halt; SYS_HALT [*5] |-> !SYS_CLK_EN; endproperty
    property p_stop; SLOW_STOP [*8] |-> !SLOW_CLK_EN; endproperty
    property p_gap; SYS_CLK_EN |=> !SYS_CLK_EN; endproperty
    property p_fast1; !(FAST_XTAL_ON && FAST_RC_ON); endproperty
    property p_slow1; !(SLOW_XTAL_ON && SLOW_RC_ON); endproperty
    property p_pind; PORT_D_GPIO_EN |-> !FAST_XTAL_ON; endproperty
    property p_pins; SLOW_PINS_GPIO_EN |-> !SLOW_XTAL_ON; endproperty

    a_lp: assert property (p_lp) else $error("low power bit not applied");
    a_por: assert property (p_por) else $error("outputs not clear after reset");
    a_rdat: assert property (p_rdat) else $error("read data without read");
    a_halt: assert property (p_halt) else $error("system clock runs in halt");
    a_stop: assert property (p_stop) else $error("slow clock runs while stopped");
    a_gap: assert property (p_gap) else $error("system pulse too long");
    a_fast1: assert property (p_fast1) else $error("two fast sources on");
    a_slow1: assert property (p_slow1) else $error("two slow sources on");
    a_pind: assert property (p_pind) else $error("port d freed with crystal on");
    a_pins: assert property (p_pins) else $error("slow pins freed with crystal on");
endmodule : ocs_clock_select_sva

bind ocs_clock_select ocs_clock_select_sva chk_u (.MCLK, .RESET, .ADDR, .WDATA, .WR, .RD,
    .RDATA, .SYS_HALT, .SLOW_STOP, .SYS_CLK_EN, .SLOW_CLK_EN, .FAST_XTAL_ON, .FAST_RC_ON,
    .SLOW_XTAL_ON, .SLOW_RC_ON, .SLOW_XTAL_LOWPOWER, .PORT_D_GPIO_EN, .SLOW_PINS_GPIO_EN);

// file: bench/ocs_osc_model.sv
/*
 * Behavioural oscillators facing the clock select block.
 * Assumes MCLK as time base; half periods are in MCLK cycles.
 */
`timescale 1ns/100ps
module ocs_osc_model #(
    parameter int HALF_F = 2,
    parameter int HALF_S = 4
) (
    input  wire logic       clk,
    input  wire logic [3:0] en,   // fast xtal, fast rc, slow xtal, slow rc
    output logic [3:0]      osc
);
    int cnt [4];
    // ****************************************
    // oscillators
    // ****************************************
    initial osc = 4'h0;
    // a stopped source idles low, so a restart never gives a short phase
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (!en[i]) begin
                osc[i] <= 1'b0;
                cnt[i] <= 0;
            end else if (cnt[i] == (i > 1 ? HALF_F : HALF_S) - 1) begin
                osc[i] <= ~osc[i];
                cnt[i] <= 0;
            end else begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end
endmodule : ocs_osc_model

// file: bench/tb.sv
/*
 * Self-checking bench of the oscillator and clock select block.
 * Assumes the oscillator model as far side and shortened slow waits.
 */
`timescale 1ns/100ps
module tb;
    import ocs_pkg::*;
    logic       MCLK = 1'b0, RESET = 1'b1, WR = 1'b0, RD = 1'b0;
    logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA;
    ocs_cfg_s   CFG = 5'h1A;
    logic       SYS_HALT = 1'b0, SLOW_STOP = 1'b0, SYS_CLK_EN, SLOW_CLK_EN;
    logic       FAST_XTAL_ON, FAST_XTAL_HI_FREQ, FAST_RC_ON, SLOW_XTAL_ON, SLOW_RC_ON;
    logic       SLOW_XTAL_LOWPOWER, PORT_D_GPIO_EN, SLOW_PINS_GPIO_EN;
    logic [1:0] FAST_RC_FREQ;
    logic [3:0] osc;
    int         failures = 0, n_checks = 0, cyc = 0;
    // ****************************************
    // clock, design and far side
    // ****************************************
    always #25 MCLK = ~MCLK;
    ocs_clock_select #(.SLOW_QS_WAIT(4), .SLOW_LP_WAIT(8)) dut_u (.MCLK, .RESET, .ADDR,
        .WDATA, .WR, .RD, .RDATA, .OSC_FAST_XTAL(osc[3]), .OSC_FAST_RC(osc[2]),
        .OSC_SLOW_XTAL(osc[1]), .OSC_SLOW_RC(osc[0]), .CFG, .SYS_HALT, .SLOW_STOP,
        .SYS_CLK_EN, .SLOW_CLK_EN, .FAST_XTAL_ON, .FAST_XTAL_HI_FREQ, .FAST_RC_ON,
        .FAST_RC_FREQ, .SLOW_XTAL_ON, .SLOW_XTAL_LOWPOWER, .SLOW_RC_ON, .PORT_D_GPIO_EN,
        .SLOW_PINS_GPIO_EN);
    ocs_osc_model osc_u (.clk(MCLK), .en({FAST_XTAL_ON, FAST_RC_ON, SLOW_XTAL_ON, SLOW_RC_ON}),
        .osc(osc));
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic end_sim;
        if (failures == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    task automatic do_rst(input ocs_cfg_s c);
        @(posedge MCLK);
        RESET <= 1'b1;
        CFG <= c;
        repeat (4) @(posedge MCLK);
        RESET <= 1'b0;
    endtask : do_rst
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        #1 chk(n, RDATA, e);
    endtask : rdc
    task automatic gap(output int n);
        n = 0;
        do begin
            @(posedge MCLK);
            #1 n++;
        end while (SYS_CLK_EN !== 1'b1 && n < 3000);
    endtask : gap
    task automatic cnt(input int w, output int s, output int f);
        s = 0;
        f = 0;
        repeat (w) begin
            @(posedge MCLK);
            #1 s += int'(SYS_CLK_EN === 1'b1);
            f += int'(SLOW_CLK_EN === 1'b1);
        end
    endtask : cnt
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs;
        rdc("mode", 8'h00, 8'h03);
        rdc("tbc", 8'h01, 8'h00);
        wr(8'h01, 8'h01);
        rdc("tbc lp", 8'h01, 8'h01);
        chk("lowpower", SLOW_XTAL_LOWPOWER, 1'b1);
        wr(8'h01, 8'h00);
        wr(8'h07, 8'hFF);
        rdc("unmapped", 8'h07, 8'h00);
        wr(8'h02, 8'h00);
        rdc("straps", 8'h02, 8'h1A);
        repeat (64) @(posedge MCLK);
        #1 chk("rc pins", {PORT_D_GPIO_EN, SLOW_PINS_GPIO_EN, FAST_RC_ON, SLOW_RC_ON,
            FAST_XTAL_ON, SLOW_XTAL_ON, FAST_RC_FREQ, FAST_XTAL_HI_FREQ}, 16'h01E2);
        wr(8'h00, 8'hF3);
        rdc("ready ro", 8'h00, 8'hFF);
    endtask : t_regs
    // every divider code, plus undivided fast, as a pulse interval
    task automatic t_div;
        int n;
        for (int i = 0; i < 9; i++) begin
            wr(8'h00, i == 8 ? 8'h03 : {i[2:0], 5'h02});
            gap(n);
            gap(n);
            gap(n);
            chk("period", n[15:0], i == 8 ? 16'h0004 : (i < 2 ? 16'h0008 :
                16'h0004 << (8 - i)));
        end
    endtask : t_div
    task automatic t_halt_stop;
        int s, f;
        @(posedge MCLK);
        SYS_HALT <= 1'b1;
        repeat (8) @(posedge MCLK);
        cnt(64, s, f);
        chk("halt sys", s[15:0], 16'h0000);
        chk("halt slow", f[15:0], 16'h0008);
        @(posedge MCLK);
        SYS_HALT <= 1'b0;
        SLOW_STOP <= 1'b1;
        repeat (16) @(posedge MCLK);
        cnt(32, s, f);
        chk("stop slow", f[15:0], 16'h0000);
        rdc("stop rdy", 8'h00, 8'h07);
        @(posedge MCLK);
        SLOW_STOP <= 1'b0;
        repeat (30) @(posedge MCLK);
        rdc("wake rdy", 8'h00, 8'h0F);
    endtask : t_halt_stop
    // crystals strapped: pins stay dedicated, both start-up waits seen
    task automatic t_xtal;
        int s, f;
        do_rst(5'h05);
        repeat (12) @(posedge MCLK);
        #1 chk("xtal pins", {PORT_D_GPIO_EN, SLOW_PINS_GPIO_EN, FAST_RC_ON, SLOW_RC_ON,
            FAST_XTAL_ON, SLOW_XTAL_ON, FAST_RC_FREQ, FAST_XTAL_HI_FREQ}, 16'h001D);
        rdc("xtal early", 8'h00, 8'h03);
        repeat (3950) @(posedge MCLK);
        rdc("slow only", 8'h00, 8'h0B);
        repeat (200) @(posedge MCLK);
        rdc("both", 8'h00, 8'h0F);
        wr(8'h01, 8'h01);
        cnt(64, s, f);
        chk("lp slow", f[15:0], 16'h0008);
        // a restart in low power must wait the longer crystal start-up
        @(posedge MCLK);
        SLOW_STOP <= 1'b1;
        repeat (4) @(posedge MCLK);
        SLOW_STOP <= 1'b0;
        repeat (40) @(posedge MCLK);
        rdc("lp slow wait", 8'h00, 8'h07);
        repeat (30) @(posedge MCLK);
        rdc("lp slow rdy", 8'h00, 8'h0F);
    endtask : t_xtal
    // ****************************************
    // sequence and watchdog
    // ****************************************
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_sim;
        end
    end
    initial begin
        do_rst(5'h1A);
        t_regs;
        t_div;
        t_halt_stop;
        t_xtal;
        end_sim;
    end
endmodule : tb
